// *** rtl/video_fetch_params.svh ***
// Register offsets, field positions, reset values and codes of the video fetch front end.
`ifndef VIDEO_FETCH_PARAMS_SVH
`define VIDEO_FETCH_PARAMS_SVH

`define REG_CTRL 8'h00
`define REG_THRESHOLD 8'h04
`define REG_FRAME_START 8'h08
`define REG_LOWER_START 8'h0C
`define REG_LINES 8'h10
`define REG_WORDS 8'h14
`define REG_PITCH 8'h18
`define REG_BLINK_PERIOD 8'h1C
`define REG_LUT_MASK 8'h20
`define REG_SUBSTITUTE 8'h24
`define REG_PLANE_MASK 8'h28
`define REG_MATCH 8'h2C
`define REG_STATUS 8'h30

`define CTRL_EN 0
`define CTRL_DUAL 1
`define CTRL_DEPTH 2
`define CTRL_OP 5
`define CTRL_LUT 8

`define THRESHOLD_RST 6'h10
`define BLINK_PERIOD_RST 8'h10
`define FIFO_WORDS 6'h20
`define FIFO_HALF 6'h10

`define DEPTH_4BPP 3'h1
`define DEPTH_8BPP 3'h2
`define DEPTH_16BPP 3'h4
`define DEPTH_32BPP 3'h5

`define OP_AND 3'h0
`define OP_OR 3'h1
`define OP_XOR 3'h2
`define OP_BACKGROUND 3'h3
`define OP_DIMMER 3'h4
`define OP_BRIGHTER 3'h5
`define OP_OFFSET 3'h6

`endif

// *** rtl/video_fetch_pkg.sv ***
// Types shared by the video fetch front end.
`default_nettype none
package video_fetch_pkg;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BURST = 1'b1
    } fetch_e;

    typedef struct packed {
        logic en;
        logic dual;
        logic [2:0] depth;
        logic [2:0] op;
        logic lut_path;
        logic [5:0] thr;
        logic [29:0] page;
        logic [29:0] hpage;
        logic [10:0] lines;
        logic [10:0] words;
        logic [15:0] pitch;
        logic [7:0] period;
        logic [7:0] bmask;
        logic [23:0] subst;
        logic [23:0] pmask;
        logic [23:0] match;
        fetch_e fsm;
        logic half;
        logic [1:0][29:0] lstart;
        logic [1:0][29:0] addr;
        logic [1:0][10:0] wcnt;
        logic [1:0][10:0] lcnt;
        logic [1:0] done;
        logic [1:0][5:0] res;
        logic [1:0][4:0] have;
        logic [1:0][3:0] wp;
        logic wpar;
        logic [3:0] rp;
        logic [5:0] outst;
        logic [5:0] drop;
        logic [63:0] pair;
        logic pair_v;
        logic [3:0] pc;
        logic out_v;
        logic [23:0] out_d;
        logic blink_on;
        logic [7:0] bcnt;
        logic uflow;
        logic uflow_p;
        logic [31:0] rdata;
    } state_s;

endpackage
`default_nettype wire

// *** rtl/video_fetch_unpack_blink.sv ***
// Frame fetch scanner, video FIFO, pixel unpacker and blink stage.
`include "video_fetch_params.svh"
`default_nettype none
module video_fetch_unpack_blink
    import video_fetch_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // SDRAM read port.
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic mem_burst,
    input wire logic mem_ack,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    // Video timing and pixel stream.
    input wire logic frame_start,
    input wire logic pix_ready,
    output logic pix_valid,
    output logic [23:0] pix_data,
    output logic fifo_underflow
);

    // ****************************************************************
    // State and storage
    // ****************************************************************

    state_s s;
    state_s n;
    logic [31:0] ram [0:31];

    logic acc;
    logic keep;
    logic wbank;
    logic avail;
    logic adv;
    logic last;
    logic consume;
    logic load;
    logic [10:0] lines_h;
    logic [1:0] full;
    logic [1:0] need;
    logic [1:0][5:0] res_inc;
    logic [1:0][5:0] res_dec;
    logic [2:0] lb;
    logic [3:0] last_pc;
    logic [5:0] off;
    logic [63:0] shifted;
    logic [23:0] dmask;
    logic [23:0] pix;
    logic is_blink;
    logic [23:0] blinked;
    logic [23:0] bout;
    logic [23:0] and_mask;
    logic [23:0] or_mask;
    logic [5:0] fill;

    // ****************************************************************
    // Fetch flow control
    // ****************************************************************

    // Single scan counts the whole FIFO in half zero; dual scan gives each half its own.
    always_comb begin
        lines_h = s.dual ? {1'b0, s.lines[10:1]} : s.lines;
        if (s.dual) begin
            full[0] = s.res[0] >= `FIFO_HALF;
            full[1] = s.res[1] >= `FIFO_HALF;
            need[0] = s.res[0] < {1'b0, s.thr[5:1]};
            need[1] = s.res[1] < {1'b0, s.thr[5:1]};
        end else begin
            full[0] = s.res[0] >= `FIFO_WORDS;
            full[1] = 1'b1;
            need[0] = s.res[0] < s.thr;
            need[1] = 1'b0;
        end
    end

    // A frame boundary withholds the request, so no word of the old frame is accepted.
    assign mem_req = (s.fsm == ST_BURST) && s.en && !frame_start
        && !full[s.half] && !s.done[s.half];
    assign acc = mem_req && mem_ack;
    assign keep = mem_rvalid && (s.drop == 6'h00);
    // Single scan alternates banks word by word, so a pair is always even then odd.
    assign wbank = s.dual ? s.half : s.wpar;
    assign mem_addr = {s.addr[s.half], 2'b00};
    assign mem_burst = s.fsm == ST_BURST;

    // ****************************************************************
    // FIFO read side and unpacker
    // ****************************************************************

    assign avail = (s.have[0] != 5'h00) && (s.have[1] != 5'h00);
    assign adv = !s.out_v || pix_ready;
    assign last = s.pc == last_pc;
    assign consume = adv && s.pair_v;
    // A pair is taken only when both banks hold a word, so even and odd never drift apart.
    assign load = avail && (!s.pair_v || (consume && last));

    always_comb begin
        case (s.depth)
            `DEPTH_4BPP: begin
                lb = 3'h2;
                dmask = 24'h00000F;
            end
            `DEPTH_16BPP: begin
                lb = 3'h4;
                dmask = 24'h00FFFF;
            end
            `DEPTH_32BPP: begin
                lb = 3'h5;
                dmask = 24'hFFFFFF;
            end
            default: begin
                lb = 3'h3;
                dmask = 24'h0000FF;
            end
        endcase
    end

    // Dual scan takes even pixels from the upper word and odd ones from the lower word.
    assign last_pc = 4'((7'h40 >> lb) - 7'h01);
    assign off = s.dual ? 6'({s.pc[0], 5'h00}) + 6'({3'h0, s.pc[3:1]} << lb)
        : 6'({2'h0, s.pc} << lb);
    assign shifted = s.pair >> off;
    assign pix = shifted[23:0] & dmask;

    // ****************************************************************
    // Blink stage
    // ****************************************************************

    // A zero plane mask with a zero match value marks every pixel as blinking.
    assign is_blink = (pix & s.pmask) == s.match;
    // For AND, OR and XOR the LUT path only touches the low byte, which is the palette address.
    assign and_mask = s.lut_path ? {16'hFFFF, s.bmask} : s.subst;
    assign or_mask = s.lut_path ? {16'h0000, s.bmask} : s.subst;

    always_comb begin
        case (s.op)
            `OP_AND: blinked = pix & and_mask;
            `OP_OR: blinked = pix | or_mask;
            `OP_XOR: blinked = pix ^ or_mask;
            `OP_BACKGROUND: blinked = s.subst;
            `OP_DIMMER: blinked = {1'b0, pix[23:17], 1'b0, pix[15:9],
                1'b0, pix[7:1]};
            `OP_BRIGHTER: blinked = {1'b1, pix[23:17], 1'b1, pix[15:9],
                1'b1, pix[7:1]};
            `OP_OFFSET: blinked = pix + s.subst;
            default: blinked = pix;
        endcase
    end

    assign bout = (s.blink_on && is_blink) ? blinked : pix;

    // ****************************************************************
    // Next state
    // ****************************************************************

    assign fill = {1'b0, s.have[0]} + {1'b0, s.have[1]};

    always_comb begin
        n = s;
        n.uflow_p = 1'b0;
        n.rdata = 32'h0000_0000;

        if (reg_wr) begin
            case (reg_addr)
                `REG_CTRL: begin
                    n.en = reg_wdata[`CTRL_EN];
                    n.dual = reg_wdata[`CTRL_DUAL];
                    n.depth = reg_wdata[`CTRL_DEPTH +: 3];
                    n.op = reg_wdata[`CTRL_OP +: 3];
                    n.lut_path = reg_wdata[`CTRL_LUT];
                end
                `REG_THRESHOLD: n.thr = reg_wdata[5:0];
                `REG_FRAME_START: n.page = reg_wdata[29:0];
                `REG_LOWER_START: n.hpage = reg_wdata[29:0];
                `REG_LINES: n.lines = reg_wdata[10:0];
                `REG_WORDS: n.words = reg_wdata[10:0];
                `REG_PITCH: n.pitch = reg_wdata[15:0];
                `REG_BLINK_PERIOD: n.period = reg_wdata[7:0];
                `REG_LUT_MASK: n.bmask = reg_wdata[7:0];
                `REG_SUBSTITUTE: n.subst = reg_wdata[23:0];
                `REG_PLANE_MASK: n.pmask = reg_wdata[23:0];
                `REG_MATCH: n.match = reg_wdata[23:0];
                `REG_STATUS: begin
                    if (reg_wdata[0]) begin
                        n.uflow = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data is zero outside the read slot, so a stale value never looks like data.
        if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL: n.rdata = {23'h0, s.lut_path, s.op, s.depth, s.dual, s.en};
                `REG_THRESHOLD: n.rdata = {26'h0, s.thr};
                `REG_FRAME_START: n.rdata = {2'h0, s.page};
                `REG_LOWER_START: n.rdata = {2'h0, s.hpage};
                `REG_LINES: n.rdata = {21'h0, s.lines};
                `REG_WORDS: n.rdata = {21'h0, s.words};
                `REG_PITCH: n.rdata = {16'h0, s.pitch};
                `REG_BLINK_PERIOD: n.rdata = {24'h0, s.period};
                `REG_LUT_MASK: n.rdata = {24'h0, s.bmask};
                `REG_SUBSTITUTE: n.rdata = {8'h0, s.subst};
                `REG_PLANE_MASK: n.rdata = {8'h0, s.pmask};
                `REG_MATCH: n.rdata = {8'h0, s.match};
                `REG_STATUS: n.rdata = {23'h0, fill, s.done[0] && s.done[1],
                    s.blink_on, s.uflow};
                default: n.rdata = 32'h0000_0000;
            endcase
        end

        // Scanner: a burst opens only when nothing is in flight, so returning words
        // always belong to the half that is being fetched.
        case (s.fsm)
            ST_IDLE: begin
                if (s.en && (s.outst == 6'h00) && !frame_start) begin
                    if (need[0] && !s.done[0]) begin
                        n.fsm = ST_BURST;
                        n.half = 1'b0;
                    end else if (need[1] && !s.done[1]) begin
                        n.fsm = ST_BURST;
                        n.half = 1'b1;
                    end
                end
            end
            ST_BURST: begin
                // Stopping at full leaves the rest of the line to the next refill.
                if (full[s.half] || s.done[s.half] || !s.en) begin
                    n.fsm = ST_IDLE;
                end
            end
            default: n.fsm = ST_IDLE;
        endcase

        if (acc) begin
            if (s.wcnt[s.half] + 11'h001 == s.words) begin
                n.wcnt[s.half] = 11'h000;
                n.lstart[s.half] = s.lstart[s.half] + {14'h0000, s.pitch};
                n.addr[s.half] = s.lstart[s.half] + {14'h0000, s.pitch};
                n.lcnt[s.half] = s.lcnt[s.half] + 11'h001;
                if (s.lcnt[s.half] + 11'h001 == lines_h) begin
                    n.done[s.half] = 1'b1;
                end
            end else begin
                n.wcnt[s.half] = s.wcnt[s.half] + 11'h001;
                n.addr[s.half] = s.addr[s.half] + 30'h0000_0001;
            end
        end

        n.outst = s.outst + {5'h00, acc} - {5'h00, mem_rvalid};
        if (mem_rvalid && (s.drop != 6'h00)) begin
            n.drop = s.drop - 6'h01;
        end

        // FIFO bookkeeping: reservations are taken when a request is accepted.
        for (int b = 0; b < 2; b++) begin
            res_inc[b] = {5'h00, acc && (s.dual ? (s.half == b[0]) : (b == 0))};
            res_dec[b] = !load ? 6'h00 : (s.dual ? 6'h01 : ((b == 0) ? 6'h02 : 6'h00));
            n.res[b] = s.res[b] + res_inc[b] - res_dec[b];
            n.have[b] = s.have[b] + {4'h0, keep && (wbank == b[0])}
                - {4'h0, load};
        end
        if (keep) begin
            n.wp[wbank] = s.wp[wbank] + 4'h1;
            if (!s.dual) begin
                n.wpar = !s.wpar;
            end
        end

        if (consume) begin
            n.out_v = 1'b1;
            n.out_d = bout;
            n.pc = s.pc + 4'h1;
            if (last) begin
                n.pair_v = 1'b0;
            end
        end else if (adv) begin
            n.out_v = 1'b0;
        end
        if (load) begin
            n.pair = {ram[{s.rp, 1'b1}], ram[{s.rp, 1'b0}]};
            n.pair_v = 1'b1;
            n.rp = s.rp + 4'h1;
            n.pc = 4'h0;
        end

        // The display asked for a pixel that was not there.
        // This set follows the software clear above, so an event in the same cycle wins.
        if (pix_ready && !s.out_v && s.en) begin
            n.uflow_p = 1'b1;
            n.uflow = 1'b1;
        end

        // ************************************************************
        // Frame boundary
        // ************************************************************

        if (frame_start) begin
            // A period of zero or one toggles the blink state on every frame.
            if ({1'b0, s.bcnt} + 9'h001 >= {1'b0, s.period}) begin
                n.bcnt = 8'h00;
                n.blink_on = !s.blink_on;
            end else begin
                n.bcnt = s.bcnt + 8'h01;
            end
            // Words still in flight arrive after the flush and are thrown away.
            n.drop = n.outst;
            n.fsm = ST_IDLE;
            n.lstart[0] = s.page;
            n.addr[0] = s.page;
            n.lstart[1] = s.hpage;
            n.addr[1] = s.hpage;
            n.wcnt = '0;
            n.lcnt = '0;
            n.done[0] = (lines_h == 11'h000) || (s.words == 11'h000);
            n.done[1] = !s.dual || (lines_h == 11'h000) || (s.words == 11'h000);
            n.res = '0;
            n.have = '0;
            n.wp = '0;
            n.wpar = 1'b0;
            n.rp = 4'h0;
            n.pair_v = 1'b0;
            n.pc = 4'h0;
            n.out_v = 1'b0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.thr <= `THRESHOLD_RST;
            s.period <= `BLINK_PERIOD_RST;
            // Both halves count as done, so nothing is fetched before the first frame boundary.
            s.done <= 2'b11;
        end else begin
            s <= n;
        end
    end

    // Dual-port RAM; the write index is the bank bit below the bank pointer.
    // The RAM has no reset; the bank counters alone decide which words are valid.
    always_ff @(posedge clk) begin
        if (keep && !frame_start) begin
            ram[{s.wp[wbank], wbank}] <= mem_rdata;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    assign reg_rdata = s.rdata;
    assign pix_valid = s.out_v;
    assign pix_data = s.out_d;
    assign fifo_underflow = s.uflow_p;

endmodule
`default_nettype wire

// *** verification/sdram_model.sv ***
// Behavioural SDRAM read port that answers the fetch scanner.
`default_nettype none
module sdram_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Read port.
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_ack,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] tick_r;
    logic [1:0] vld_r;
    logic [1:0][31:0] dat_r;
    // Every fourth cycle stalls, so a burst sees both prompt and slow acceptance.
    assign mem_ack = mem_req && tick_r != 2'h3;
    assign mem_rvalid = vld_r[1];
    // Between words the lines repeat the last word once, then alternate between its inverse and the word itself.
    assign mem_rdata = vld_r[1] ? dat_r[1] : ~dat_r[1];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_r <= 2'h0;
            vld_r <= 2'h0;
            dat_r <= '0;
        end else begin
            tick_r <= tick_r + 2'h1;
            vld_r <= {vld_r[0], mem_ack};
            dat_r[1] <= dat_r[0];
            dat_r[0] <= mem_ack ? {8'h00, mem_addr[9:2] ^ 8'h3C, 16'h81F0} : ~dat_r[0];
        end
    end
endmodule
`default_nettype wire

// *** verification/video_fetch_props.sv ***
// Concurrent checks on the ports of the video fetch front end.
`default_nettype none
module video_fetch_props (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Register port.
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Memory and pixel side.
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic mem_burst,
    input wire logic mem_ack,
    input wire logic frame_start,
    input wire logic pix_ready,
    input wire logic pix_valid,
    input wire logic [23:0] pix_data,
    input wire logic fifo_underflow
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_no_req_frame;
        frame_start |-> !mem_req;
    endproperty
    a_no_req_frame: assert property (p_no_req_frame) else $error("request at frame start");
    property p_req_burst;
        mem_req |-> mem_burst && mem_addr[1:0] == 2'h0;
    endproperty
    a_req_burst: assert property (p_req_burst) else $error("request outside burst");
    property p_burst_open;
        $rose(mem_burst) |-> mem_req;
    endproperty
    a_burst_open: assert property (p_burst_open) else $error("burst opened idle");
    property p_burst_close;
        $fell(mem_burst) |-> !$past(mem_req);
    endproperty
    a_burst_close: assert property (p_burst_close) else $error("burst closed early");
    property p_addr_hold;
        mem_req && !mem_ack && !frame_start |=> mem_addr == $past(mem_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved without ack");
    property p_pix_hold;
        pix_valid && !pix_ready && !frame_start |=> pix_valid && $stable(pix_data);
    endproperty
    a_pix_hold: assert property (p_pix_hold) else $error("pixel dropped before taken");
    property p_flush;
        frame_start |=> !pix_valid;
    endproperty
    a_flush: assert property (p_flush) else $error("pixel kept across frame start");
    property p_uflow;
        fifo_underflow |-> $past(pix_ready) && !$past(pix_valid);
    endproperty
    a_uflow: assert property (p_uflow) else $error("underflow without demand");
endmodule
bind video_fetch_unpack_blink video_fetch_props u_props (
    .clk, .arst_n, .reg_rd, .reg_rdata, .mem_req, .mem_addr, .mem_burst, .mem_ack,
    .frame_start, .pix_ready, .pix_valid, .pix_data, .fifo_underflow
);
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking testbench for the video fetch front end.
`include "video_fetch_params.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [2:0] d;
        logic [2:0] op;
        logic lut;
        logic [23:0] pm;
        logic [23:0] e;
    } row_s;
    // Substitute 123456, LUT mask 3C; fetched word gives pixel 7C81F0.
    row_s rows[13] = '{
        '{`DEPTH_32BPP, `OP_AND, 1'b0, 24'h0, 24'h100050},
        '{`DEPTH_32BPP, `OP_OR, 1'b0, 24'h0, 24'h7EB5F6},
        '{`DEPTH_32BPP, `OP_XOR, 1'b0, 24'h0, 24'h6EB5A6},
        '{`DEPTH_32BPP, `OP_BACKGROUND, 1'b0, 24'h0, 24'h123456},
        '{`DEPTH_32BPP, `OP_DIMMER, 1'b0, 24'h0, 24'h3E4078},
        '{`DEPTH_32BPP, `OP_BRIGHTER, 1'b0, 24'h0, 24'hBEC0F8},
        '{`DEPTH_32BPP, `OP_OFFSET, 1'b0, 24'h0, 24'h8EB646},
        '{`DEPTH_8BPP, `OP_AND, 1'b1, 24'h0, 24'h000030},
        '{`DEPTH_8BPP, `OP_OR, 1'b1, 24'h0, 24'h0000FC},
        '{`DEPTH_8BPP, `OP_XOR, 1'b1, 24'h0, 24'h0000CC},
        '{`DEPTH_32BPP, `OP_BACKGROUND, 1'b0, 24'hFFFFFF, 24'h7C81F0},
        '{`DEPTH_16BPP, `OP_DIMMER, 1'b0, 24'h0, 24'h004078},
        '{`DEPTH_4BPP, `OP_XOR, 1'b1, 24'h0, 24'h00003C}
    };
    logic [31:0] exp_addr[6] = '{32'h100, 32'h104, 32'h114, 32'h118, 32'h128, 32'h12C};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic frame_start = 1'b0;
    logic pix_ready = 1'b0;
    logic [31:0] reg_rdata, mem_addr, mem_rdata, v;
    logic mem_req, mem_burst, mem_ack, mem_rvalid, pix_valid, fifo_underflow;
    logic [23:0] pix_data, p;
    logic [31:0] acc[$];
    int err_count = 0;
    int checks_done = 0;
    always #4 clk = ~clk;
    video_fetch_unpack_blink uut (
        .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_req,
        .mem_addr, .mem_burst, .mem_ack, .mem_rvalid, .mem_rdata, .frame_start,
        .pix_ready, .pix_valid, .pix_data, .fifo_underflow
    );
    sdram_model mem (.clk, .arst_n, .mem_req, .mem_addr, .mem_ack, .mem_rvalid, .mem_rdata);
    always @(negedge clk) begin
        if (mem_req === 1'b1 && mem_ack === 1'b1) acc.push_back(mem_addr);
    end
    // ****************
    // Bus tasks
    // ****************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic frame();
        frame_start <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        @(posedge clk);
    endtask
    task automatic setup(input logic [31:0] ctrl, input logic [10:0] lines, input logic [15:0] pt);
        wr(`REG_FRAME_START, 32'h40);
        wr(`REG_LOWER_START, 32'h80);
        wr(`REG_LINES, {21'h0, lines});
        wr(`REG_WORDS, 32'h2);
        wr(`REG_PITCH, {16'h0, pt});
        wr(`REG_CTRL, ctrl);
        acc.delete();
        frame();
    endtask
    task automatic get_pix(output logic [23:0] d);
        int i;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (pix_valid !== 1'b1 && i < 300);
        d = pix_data;
        @(posedge clk);
        pix_ready <= 1'b1;
        @(posedge clk);
        pix_ready <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
    // ****************
    // Scenarios
    // ****************
    initial begin
        do_reset();
        rd(`REG_THRESHOLD, v);
        chk("threshold", 32'h10, v);
        rd(`REG_BLINK_PERIOD, v);
        chk("blink period", 32'h10, v);
        rd(8'h3C, v);
        chk("unmapped", 32'h0, v);
        $display("Test reset values done");
        foreach (rows[i]) begin
            do_reset();
            wr(`REG_SUBSTITUTE, 32'h123456);
            wr(`REG_LUT_MASK, 32'h3C);
            wr(`REG_PLANE_MASK, {8'h0, rows[i].pm});
            wr(`REG_MATCH, 32'h0);
            wr(`REG_BLINK_PERIOD, 32'h1);
            setup({23'h0, rows[i].lut, rows[i].op, rows[i].d, 2'b01}, 11'h4, 16'h2);
            get_pix(p);
            chk("pixel", {8'h0, rows[i].e}, {8'h0, p});
        end
        $display("Test blink table done");
        do_reset();
        setup(32'h15, 11'h3, 16'h5);
        pix_ready <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("underflow pin", 32'h1, 32'(fifo_underflow));
        repeat (200) @(posedge clk);
        pix_ready <= 1'b0;
        @(posedge clk);
        chk("words fetched", 32'h6, 32'(acc.size()));
        foreach (exp_addr[i]) chk("fetch address", exp_addr[i], acc[i]);
        rd(`REG_STATUS, v);
        chk("frame done", 32'h1, 32'(v[2]));
        chk("underflow", 32'h1, 32'(v[0]));
        wr(`REG_STATUS, 32'h1);
        rd(`REG_STATUS, v);
        chk("underflow clear", 32'h0, 32'(v[0]));
        $display("Test pitch and underflow done");
        do_reset();
        setup(32'h17, 11'h4, 16'h2);
        get_pix(p);
        chk("upper pixel", 32'h7C81F0, {8'h0, p});
        get_pix(p);
        chk("lower pixel", 32'hBC81F0, {8'h0, p});
        $display("Test dual scan done");
        do_reset();
        wr(`REG_BLINK_PERIOD, 32'h2);
        for (int i = 1; i < 5; i++) begin
            frame();
            rd(`REG_STATUS, v);
            chk("blink state", 32'(i == 2 || i == 3), 32'(v[1]));
        end
        $display("Test blink period done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
